// >>> hdl/adcfg_serial_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: frame is exactly sixteen serial clocks
// R2: top three bits form address code
// R3: write flag zero ignores frame
// R4: code 100 loads twelve control bits
// R5: code 101 loads eight range bits
// R6: code 111 loads four sequence bits
// R7: registers are write-only, no readback
// R8: control register clears at power-up
// R9: control applies from next conversion; power bits 7:6 reach power_mode at frame end instead
// R10: host writes zero to bits 12, 1
// R11: bits 11:10 select channel or last
// R12: bits 9:8 select input grouping
// R13: single-ended routes input against ground
// R14: three pseudo inputs share input 3
// R15: pair modes route 0/1 or 2/3
// R16: bits 7:6 select power mode
// R17: bit 5 selects result coding
// R18: bit 4 selects reference source
// R19: bits 3:2 select sequencer function
// R20: host programs range, sequence first
// R21: power encoding, auto modes at edge 15
// R22: sequencer encoding off/flagged/consecutive
// R23: range two bits per channel, default 00
// R24: sequence bit includes its channel
// R25: other write codes load nothing
// R26: short frames modify no register
module adcfg_serial_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic serial_clk,
	input wire logic frame_sel_n,
	input wire logic serial_in,
	input wire logic conversion_start,
	output logic [11:0] conversion_control,
	output logic [7:0] range_bits,
	output logic [3:0] sequence_bits,
	output logic [1:0] active_channel,
	output logic [1:0] active_pairing,
	output logic active_straight_binary,
	output logic active_internal_ref,
	output logic [1:0] cycle_mode,
	output logic [1:0] power_mode,
	output logic power_auto_engaged,
	output logic [2:0] route_pos,
	output logic [2:0] route_neg,
	output logic route_forbidden
);
	// ***********************************
	// pin synchronisers and edge finding
	// ***********************************
	logic [1:0] sclk_sync;
	logic [1:0] cs_sync;
	logic [1:0] din_sync;
	logic sclk_prev;
	// two flops per pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_sync <= 2'h3;
			cs_sync <= 2'h3;
			din_sync <= 2'h0;
			sclk_prev <= 1'b1;
		end else begin
			sclk_sync <= {sclk_sync[0], serial_clk};
			cs_sync <= {cs_sync[0], frame_sel_n};
			din_sync <= {din_sync[0], serial_in};
			sclk_prev <= sclk_sync[1];
		end
	end
	logic sclk_fall;
	logic sclk_rise;
	logic framing;
	assign sclk_fall = sclk_prev & ~sclk_sync[1];
	assign sclk_rise = ~sclk_prev & sclk_sync[1];
	assign framing = ~cs_sync[1];

	// ***********************************
	// frame shifter
	// ***********************************
	logic [15:0] shift;
	logic [4:0] bit_count;
	logic [4:0] rise_count;
	logic frame_done;
	logic [15:0] next_shift;
	assign next_shift = {shift[14:0], din_sync[1]};
	// R1: count sixteen bits, sample on falling edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift <= 16'h0000;
			bit_count <= 5'h00;
			frame_done <= 1'b0;
		end else begin
			frame_done <= 1'b0;
			if (!framing) begin
				// R26: abort discards partial frame
				bit_count <= 5'h00;
			end else if (sclk_fall && bit_count < 5'(adcfg_pkg::FRAME_BITS)) begin
				shift <= next_shift;
				bit_count <= bit_count + 5'h01;
				frame_done <= (bit_count == 5'(adcfg_pkg::FRAME_BITS - 1));
			end
		end
	end
	// rising edges seen in the current frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rise_count <= 5'h00;
		end else if (!framing) begin
			rise_count <= 5'h00;
		end else if (sclk_rise && rise_count != 5'h1f) begin
			rise_count <= rise_count + 5'h01;
		end
	end

	// ***********************************
	// address decode and register load
	// ***********************************
	logic [2:0] code;
	// R2: write flag, select 1, select 2
	assign code = {shift[adcfg_pkg::WRITE_POS], shift[adcfg_pkg::SEL1_POS],
		shift[adcfg_pkg::SEL2_POS]};
	logic ctl_loaded;
	// R4: control load; R8: cleared at power-up
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conversion_control <= adcfg_pkg::CONTROL_RESET;
			ctl_loaded <= 1'b0;
		end else begin
			ctl_loaded <= 1'b0;
			// R3: write flag zero never matches a code
			if (frame_done && code == adcfg_pkg::CODE_CONTROL) begin
				conversion_control <= shift[adcfg_pkg::CTL_MSB:adcfg_pkg::CTL_LSB];
				ctl_loaded <= 1'b1;
			end
		end
	end
	// R5: range load; R23: two bits per channel
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			range_bits <= adcfg_pkg::RANGE_RESET;
		end else if (frame_done && code == adcfg_pkg::CODE_RANGE) begin
			range_bits <= shift[adcfg_pkg::RNG_MSB:adcfg_pkg::RNG_LSB];
		end
	end
	// R6: sequence load; R24: one flag per channel
	// R25: other codes fall through unchanged
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sequence_bits <= adcfg_pkg::SEQUENCE_RESET;
		end else if (frame_done && code == adcfg_pkg::CODE_SEQUENCE) begin
			sequence_bits <= shift[adcfg_pkg::SEQ_MSB:adcfg_pkg::SEQ_LSB];
		end
	end
	// R7: no readback path exists; outputs feed the converter only

	// ***********************************
	// settings for the next conversion
	// ***********************************
	// R9: latch control fields at conversion start
	// R11: channel; R12: grouping; R17: coding; R18: reference
	// R19: R22: sequencer function
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_channel <= 2'h0;
			active_pairing <= 2'h0;
			active_straight_binary <= 1'b0;
			active_internal_ref <= 1'b0;
			cycle_mode <= 2'h0;
		end else if (conversion_start) begin
			active_channel <= conversion_control[adcfg_pkg::CHAN_MSB:adcfg_pkg::CHAN_LSB];
			active_pairing <= conversion_control[adcfg_pkg::PAIR_MSB:adcfg_pkg::PAIR_LSB];
			active_straight_binary <= conversion_control[adcfg_pkg::CODING_POS];
			active_internal_ref <= conversion_control[adcfg_pkg::REF_POS];
			cycle_mode <= {conversion_control[adcfg_pkg::CYCLE_A_POS],
				conversion_control[adcfg_pkg::CYCLE_B_POS]};
		end
	end

	// ***********************************
	// power mode
	// ***********************************
	logic auto_pending;
	logic [1:0] ctl_power;
	assign ctl_power = {conversion_control[adcfg_pkg::POWER_HI],
		conversion_control[adcfg_pkg::POWER_LO]};
	// R16: R21: auto modes engage on edge 15 of a later frame
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_mode <= adcfg_pkg::POWER_NORMAL;
			power_auto_engaged <= 1'b0;
			auto_pending <= 1'b0;
		end else begin
			if (ctl_loaded) begin
				power_mode <= ctl_power;
				power_auto_engaged <= 1'b0;
				auto_pending <= (ctl_power == adcfg_pkg::POWER_STANDBY) ||
					(ctl_power == adcfg_pkg::POWER_AUTOSHUT);
			end else if (auto_pending && sclk_rise && framing &&
				rise_count == adcfg_pkg::POWER_EDGE - 5'h01) begin
				power_auto_engaged <= 1'b1;
				auto_pending <= 1'b0;
			end
		end
	end

	// ***********************************
	// input routing
	// ***********************************
	logic [2:0] next_pos;
	logic [2:0] next_neg;
	logic next_forbidden;
	always_comb begin
		next_pos = 3'h0;
		next_neg = adcfg_pkg::ROUTE_GROUND;
		next_forbidden = 1'b0;
		case (active_pairing)
			// R13: input n against ground
			adcfg_pkg::PAIR_SINGLE: begin
				next_pos = {1'b0, active_channel};
				next_neg = adcfg_pkg::ROUTE_GROUND;
			end
			// R14: inputs 0..2 against input 3
			adcfg_pkg::PAIR_PSEUDO3: begin
				next_pos = {1'b0, active_channel};
				next_neg = 3'h3;
				next_forbidden = (active_channel == 2'h3);
			end
			// R15: pairs 0/1 and 2/3
			default: begin
				next_pos = {1'b0, active_channel[1], 1'b0};
				next_neg = {1'b0, active_channel[1], 1'b1};
			end
		endcase
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			route_pos <= 3'h0;
			route_neg <= adcfg_pkg::ROUTE_GROUND;
			route_forbidden <= 1'b0;
		end else begin
			route_pos <= next_pos;
			route_neg <= next_neg;
			route_forbidden <= next_forbidden;
		end
	end

	// ***********************************
	// checks
	// ***********************************
	// R4: control follows frame within a cycle
	ctl_load_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
		frame_done && code == adcfg_pkg::CODE_CONTROL |=> conversion_control == $past(shift[11:0]))
		else $error("control not loaded");
	// R3: ignored frame keeps all registers
	no_write_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
		frame_done && !shift[15] |=> $stable(conversion_control) && $stable(range_bits)
		&& $stable(sequence_bits)) else $error("write-flag zero changed a register");
	// R5: range load
	range_load_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
		frame_done && code == adcfg_pkg::CODE_RANGE |=> range_bits == $past(shift[12:5]))
		else $error("range not loaded");
	// R6: sequence load
	seq_load_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
		frame_done && code == adcfg_pkg::CODE_SEQUENCE |=> sequence_bits == $past(shift[12:9]))
		else $error("sequence not loaded");
	// R26: control and range change only after a full frame
	full_frame_a: assert property (@(posedge clk) disable iff (!rst_n) // R26
		!$past(frame_done) |-> $stable(conversion_control) && $stable(range_bits))
		else $error("register changed without full frame");
	// R25: unmatched code keeps control
	odd_code_a: assert property (@(posedge clk) disable iff (!rst_n) // R25
		frame_done && (code == 3'h6) |=> $stable(conversion_control) && $stable(sequence_bits))
		else $error("unmatched code loaded");
	// R9: active channel moves only at conversion start
	next_conv_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
		!conversion_start |=> $stable(active_channel) && $stable(cycle_mode))
		else $error("setting changed mid conversion");
	// R14: forbidden flagged one cycle after setting
	forbid_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
		active_pairing == 2'h3 && active_channel == 2'h3 |=> route_forbidden)
		else $error("forbidden selection not flagged");
	// R1: sixteen edges give exactly one done
	bit_count_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
		frame_done |-> bit_count == 5'h10) else $error("frame done off count");
	// R16: power mode follows control bits 7:6
	power_copy_a: assert property (@(posedge clk) disable iff (!rst_n) // R16
		ctl_loaded |=> power_mode == $past(conversion_control[7:6]))
		else $error("power mode not copied");
	// R21: auto modes engage on fifteenth rise
	power_auto_a: assert property (@(posedge clk) disable iff (!rst_n) // R21
		$rose(power_auto_engaged) |-> $past(sclk_rise) && $past(rise_count) == 5'h0e
		&& (power_mode == adcfg_pkg::POWER_STANDBY || power_mode == adcfg_pkg::POWER_AUTOSHUT))
		else $error("auto power engaged off edge");
	// R13: single-ended input against ground
	route_gnd_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
		active_pairing == adcfg_pkg::PAIR_SINGLE |=> route_neg == adcfg_pkg::ROUTE_GROUND
		&& route_pos == {1'b0, $past(active_channel)})
		else $error("single-ended route wrong");
	cov_ctl_c: cover property (@(posedge clk) frame_done && code == adcfg_pkg::CODE_CONTROL);
	cov_rng_c: cover property (@(posedge clk) frame_done && code == adcfg_pkg::CODE_RANGE);
	cov_seq_c: cover property (@(posedge clk) frame_done && code == adcfg_pkg::CODE_SEQUENCE);
	cov_auto_c: cover property (@(posedge clk) $rose(power_auto_engaged));
endmodule : adcfg_serial_regs
`default_nettype wire

// >>> include/adcfg_pkg.sv
`default_nettype none
package adcfg_pkg;
	// frame shape
	localparam int FRAME_BITS = 16;
	localparam int WRITE_POS = 15;
	localparam int SEL1_POS = 14;
	localparam int SEL2_POS = 13;
	// address codes {write, select1, select2}
	localparam logic [2:0] CODE_CONTROL = 3'h4;
	localparam logic [2:0] CODE_RANGE = 3'h5;
	localparam logic [2:0] CODE_SEQUENCE = 3'h7;
	// control field positions (frame bits)
	localparam int CTL_MSB = 11;
	localparam int CTL_LSB = 0;
	localparam int RNG_MSB = 12;
	localparam int RNG_LSB = 5;
	localparam int SEQ_MSB = 12;
	localparam int SEQ_LSB = 9;
	localparam int CHAN_MSB = 11;
	localparam int CHAN_LSB = 10;
	localparam int PAIR_MSB = 9;
	localparam int PAIR_LSB = 8;
	localparam int POWER_HI = 7;
	localparam int POWER_LO = 6;
	localparam int CODING_POS = 5;
	localparam int REF_POS = 4;
	localparam int CYCLE_A_POS = 3;
	localparam int CYCLE_B_POS = 2;
	// reset values
	localparam logic [11:0] CONTROL_RESET = 12'h000;
	localparam logic [7:0] RANGE_RESET = 8'h00;
	localparam logic [3:0] SEQUENCE_RESET = 4'h0;
	// input grouping codes
	localparam logic [1:0] PAIR_SINGLE = 2'h0;
	localparam logic [1:0] PAIR_PSEUDO2 = 2'h1;
	localparam logic [1:0] PAIR_DIFF2 = 2'h2;
	localparam logic [1:0] PAIR_PSEUDO3 = 2'h3;
	// power codes
	localparam logic [1:0] POWER_NORMAL = 2'h0;
	localparam logic [1:0] POWER_STANDBY = 2'h1;
	localparam logic [1:0] POWER_AUTOSHUT = 2'h2;
	localparam logic [1:0] POWER_FULLOFF = 2'h3;
	// sequencer codes
	localparam logic [1:0] CYCLE_FLAGGED = 2'h1;
	localparam logic [1:0] CYCLE_CONSEC = 2'h2;
	// input routing: 3'h4 means analog ground
	localparam logic [2:0] ROUTE_GROUND = 3'h4;
	// rising edge on which automatic power modes engage
	localparam logic [4:0] POWER_EDGE = 5'h0f;
endpackage : adcfg_pkg
`default_nettype wire

// >>> sim/adcfg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serial host driving write frames
// ****************************************
module adcfg_host_model (
	output logic serial_clk,
	output logic frame_sel_n,
	output logic serial_in
);
	// idle: clock high, frame deselected
	initial begin
		serial_clk = 1'b1;
		frame_sel_n = 1'b1;
		serial_in = 1'b0;
	end
	// shift the top nbits of a frame, msb first, data set while clock high
	task automatic send(input logic [15:0] frame, input int nbits);
		// step off the clock edge so pins never race the sampler
		#1 frame_sel_n = 1'b0;
		for (int i = 15; i > 15 - nbits; i--) begin
			serial_in = frame[i];
			#62.5 serial_clk = 1'b0;
			#62.5 serial_clk = 1'b1;
		end
		#50 frame_sel_n = 1'b1;
		serial_in = ~serial_in; // released line shows no stale level
		#100;
	endtask : send
endmodule : adcfg_host_model
`default_nettype wire

// >>> sim/adcfg_serial_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serial config register bench
// ****************************************
module adcfg_serial_regs_tb;
	logic clk, rst_n, conversion_start, serial_clk, frame_sel_n, serial_in;
	logic [11:0] conversion_control;
	logic [7:0] range_bits;
	logic [3:0] sequence_bits;
	logic [1:0] active_channel, active_pairing, cycle_mode, power_mode;
	logic active_straight_binary, active_internal_ref, power_auto_engaged, route_forbidden;
	logic [2:0] route_pos, route_neg, ep, en;
	logic [11:0] ctl;
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;

	adcfg_serial_regs dut (.clk, .rst_n, .serial_clk, .frame_sel_n, .serial_in,
		.conversion_start, .conversion_control, .range_bits, .sequence_bits,
		.active_channel, .active_pairing, .active_straight_binary, .active_internal_ref,
		.cycle_mode, .power_mode, .power_auto_engaged, .route_pos, .route_neg,
		.route_forbidden);
	adcfg_host_model host (.serial_clk, .frame_sel_n, .serial_in);

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			results();
		end
	end
	task automatic results();
		if (fail_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : results
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one frame, then realign to the falling clock edge
	task automatic frame(input logic [15:0] f, input int n);
		host.send(f, n);
		@(negedge clk);
	endtask : frame
	// latch control for the next conversion
	task automatic pulse();
		@(negedge clk) conversion_start = 1'b1;
		@(negedge clk) conversion_start = 1'b0;
		repeat (3) @(negedge clk);
	endtask : pulse

	// main sequence
	initial begin
		rst_n = 1'b0;
		conversion_start = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		check(conversion_control, 12'h000);
		check(range_bits, 8'h00);
		check(sequence_bits, 4'h0);
		check(route_neg, 3'h4);
		frame({adcfg_pkg::CODE_RANGE, 8'ha5, 5'h00}, 16);
		check(range_bits, 8'ha5);
		frame({adcfg_pkg::CODE_SEQUENCE, 4'h9, 9'h000}, 16);
		check(sequence_bits, 4'h9);
		// refused frames: read flag, unused code, short frame
		frame({3'h0, 13'h1fff}, 16);
		frame({3'h6, 13'h1fff}, 16);
		frame({adcfg_pkg::CODE_CONTROL, 13'h0ffc}, 15);
		check(range_bits, 8'ha5);
		check(sequence_bits, 4'h9);
		check(conversion_control, 12'h000);
		// chan 2, single, standby, straight, internal, flagged
		frame({adcfg_pkg::CODE_CONTROL, 1'b0, 12'h874}, 16);
		check(conversion_control, 12'h874);
		check(power_mode, 2'h1);
		check(active_channel, 2'h0);
		check(power_auto_engaged, 1'b0);
		pulse();
		check(active_channel, 2'h2);
		check(active_straight_binary, 1'b1);
		check(active_internal_ref, 1'b1);
		check(cycle_mode, 2'h1);
		frame({3'h0, 13'h0000}, 16);
		check(power_auto_engaged, 1'b1);
		// every grouping, channel, power and sequencer code
		for (int p = 0; p < 4; p++) begin
			for (int c = 0; c < 4; c++) begin
				ctl = {c[1:0], p[1:0], p[1:0], c[0], p[0], c[1:0], 2'h0};
				frame({adcfg_pkg::CODE_CONTROL, 1'b0, ctl}, 16);
				pulse();
				case (p)
					0: begin
						ep = {1'b0, c[1:0]};
						en = 3'h4;
					end
					3: begin
						ep = {1'b0, c[1:0]};
						en = 3'h3;
					end
					default: begin
						ep = c[1] ? 3'h2 : 3'h0;
						en = c[1] ? 3'h3 : 3'h1;
					end
				endcase
				check(conversion_control, ctl);
				check(active_pairing, p[1:0]);
				check(power_mode, p[1:0]);
				check(power_auto_engaged, 1'b0);
				check(cycle_mode, c[1:0]);
				check(active_straight_binary, c[0]);
				check(active_internal_ref, p[0]);
				check(route_forbidden, (p == 3 && c == 3) ? 1'b1 : 1'b0);
				if (!(p == 3 && c == 3)) begin
					check(route_pos, ep);
					check(route_neg, en);
				end
			end
		end
		results();
	end
endmodule : adcfg_serial_regs_tb
`default_nettype wire
